// file: shared/gpab_pkg.sv
// package for the two-port gpio block: register offsets, widths, reset values
// assumes a plain byte-wide register port with one-cycle read latency
package gpab_pkg;
    localparam int          GPAB_AW          = 4;
    localparam int          GPAB_DW          = 8;
    // register offsets
    localparam logic [3:0]  GPAB_OFF_PTA     = 4'h0;
    localparam logic [3:0]  GPAB_OFF_PTB     = 4'h1;
    localparam logic [3:0]  GPAB_OFF_DIRA    = 4'h4;
    localparam logic [3:0]  GPAB_OFF_DIRB    = 4'h5;
    localparam logic [3:0]  GPAB_OFF_PORT_A_LED_DRIVE_ENABLE    = 4'hc;
    // reset values
    localparam logic [7:0]  GPAB_DIR_RST     = 8'h00;
    localparam logic [7:0]  GPAB_LED_RST     = 8'h00;
    localparam logic [7:0]  GPAB_UNMAP_RD    = 8'h00;
    // analog channel select field width and pin count on port a
    localparam int          GPAB_ACH_W       = 5;
    localparam logic [4:0]  GPAB_ACH_PINS    = 5'h08;
    // port b open-drain pins are bits 3..0
    localparam logic [7:0]  GPAB_OD_MASK     = 8'h0f;
    // timer edge/level select code for "pin is general i/o"
    localparam logic [1:0]  GPAB_ELS_GPIO    = 2'h0;
endpackage

// file: rtl/gpab_pin.sv
// one port pin: direction/data mux with optional alternate-function override
// assumes the pad outside resolves o_out/o_oe into a wire level
`timescale 1ns/1ps
module gpab_pin
    import gpab_pkg::*;
#(
    parameter bit OPEN_DRAIN = 1'b0
) (
    input  wire logic i_dir,
    input  wire logic i_latch,
    input  wire logic i_pin,
    input  wire logic i_alt_en,
    input  wire logic i_alt_out,
    input  wire logic i_alt_oe,
    output logic      o_out,
    output logic      o_oe,
    output logic      o_rd
);
    // port-controlled drive, then alternate override
    wire   port_oe   = i_dir;
    wire   sel_out   = i_alt_en ? i_alt_out : i_latch;
    wire   sel_oe    = i_alt_en ? i_alt_oe : port_oe;
    // open drain only pulls low; a high just releases the line
    assign o_out     = OPEN_DRAIN ? 1'b0 : sel_out;
    assign o_oe      = OPEN_DRAIN ? (sel_oe & ~sel_out) : sel_oe;
    // readback: latch for outputs, live pin for inputs
    assign o_rd      = i_dir ? i_latch : i_pin;
endmodule

// file: rtl/gpab_regs.sv
// byte register: plain storage with write strobe, optional reset
// assumes writes come one cycle long from the register port decode
`timescale 1ns/1ps
module gpab_regs
    import gpab_pkg::*;
#(
    parameter int         W       = 8,
    parameter bit         HAS_RST = 1'b1,
    parameter logic [7:0] RST_VAL = 8'h00
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic         i_we,
    input  wire logic [W-1:0] i_wdata,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] val_q;
    // latch registers skip reset so their contents survive it
    always_ff @(posedge i_clk) begin
        if (HAS_RST && !i_rst_n) begin
            val_q <= RST_VAL[W-1:0];
        end else if (i_we) begin
            val_q <= i_wdata;
        end
    end
    assign o_q = val_q;
endmodule

// file: rtl/gpab_top.sv
// two eight-bit gpio ports with led drive and alternate-function handover
// assumes synchronous pad inputs, one clock, and a byte register port
// How it works
// R1: selected analog pin ignores port control
// R2: unselected port a pins are digital i/o
// R3: port a direction 1 drives, 0 floats
// R4: reset clears port a direction
// R5: software writes latch before enabling output
// R6: port a read gives latch or pin
// R7: data writes always update latches
// R8: input pin write changes latch only
// R9: led drive only when pin is output
// R10: led bit selects high-current sink mode
// R11: port b pins 3..0 are open-drain
// R12: reset keeps port b latches
// R13: iic enable takes port b 0,1
// R14: serial enable takes port b 2,3
// R15: first timer select takes port b 4,5
// R16: second timer select takes port b 6,7
// R17: reset clears port b direction
// R18: port b direction 1 drives, 0 floats
// R19: port b read gives latch or pin
// R20: reset keeps port a latches
// R21: alternate function outranks port settings
`timescale 1ns/1ps
module gpab_top
    import gpab_pkg::*;
(
    input  wire logic                  i_clk,
    input  wire logic                  i_rst_n,
    // register port
    input  wire logic [GPAB_AW-1:0]    i_addr,
    input  wire logic [GPAB_DW-1:0]    i_wdata,
    input  wire logic                  i_wr,
    input  wire logic                  i_rd,
    output logic      [GPAB_DW-1:0]    o_rdata,
    // port a pads
    input  wire logic [7:0]            i_pa_pin,
    output logic      [7:0]            o_pa_out,
    output logic      [7:0]            o_pa_oe,
    output logic      [7:0]            o_pa_led_hi,
    output logic      [7:0]            o_pa_analog,
    // port b pads
    input  wire logic [7:0]            i_pb_pin,
    output logic      [7:0]            o_pb_out,
    output logic      [7:0]            o_pb_oe,
    // converter channel select
    input  wire logic [GPAB_ACH_W-1:0] i_analog_channel_select,
    // iic handover
    input  wire logic                  i_iic_block_enable,
    input  wire logic                  i_iic_sda_out,
    input  wire logic                  i_iic_sda_oe,
    input  wire logic                  i_iic_scl_out,
    input  wire logic                  i_iic_scl_oe,
    // serial handover: transmit drives pin 2, receive listens on pin 3
    input  wire logic                  i_serial_block_enable,
    input  wire logic                  i_serial_txd,
    // timer handover, edge/level select per channel
    input  wire logic [1:0]            i_t1c0_edge_level_select,
    input  wire logic [1:0]            i_t1c1_edge_level_select,
    input  wire logic [1:0]            i_t2c0_edge_level_select,
    input  wire logic [1:0]            i_t2c1_edge_level_select,
    input  wire logic [3:0]            i_timer_out,
    input  wire logic [3:0]            i_timer_oe,
    // pin levels fed back to the peripherals
    output logic      [7:0]            o_pb_level
);
    logic [7:0] pta_q;
    logic [7:0] ptb_q;
    logic [7:0] dira_q;
    logic [7:0] dirb_q;
    logic [7:0] port_a_led_drive_enable_q;
    logic [7:0] rdata_q;
    logic [7:0] pa_out_q;
    logic [7:0] pa_oe_q;
    logic [7:0] pa_led_q;
    logic [7:0] pa_an_q;
    logic [7:0] pb_out_q;
    logic [7:0] pb_oe_q;
    logic [7:0] pb_lvl_q;
    logic [7:0] pa_out_d;
    logic [7:0] pa_oe_d;
    logic [7:0] pa_rd;
    logic [7:0] pb_out_d;
    logic [7:0] pb_oe_d;
    logic [7:0] pb_rd;

    // address decode
    wire sel_pta  = (i_addr == GPAB_OFF_PTA);
    wire sel_ptb  = (i_addr == GPAB_OFF_PTB);
    wire sel_dira = (i_addr == GPAB_OFF_DIRA);
    wire sel_dirb = (i_addr == GPAB_OFF_DIRB);
    wire sel_port_a_led_drive_enable = (i_addr == GPAB_OFF_PORT_A_LED_DRIVE_ENABLE);

    // R7: latch write ignores direction
    // R20: port a latch keeps value across reset
    gpab_regs #(.W(8), .HAS_RST(1'b0), .RST_VAL(8'h00)) u_pta (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_we    (i_wr & sel_pta),
        .i_wdata (i_wdata),
        .o_q     (pta_q)
    );
    // R12: port b latch keeps value across reset
    gpab_regs #(.W(8), .HAS_RST(1'b0), .RST_VAL(8'h00)) u_ptb (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_we    (i_wr & sel_ptb),
        .i_wdata (i_wdata),
        .o_q     (ptb_q)
    );
    // R4: port a direction clears at reset
    gpab_regs #(.W(8), .HAS_RST(1'b1), .RST_VAL(GPAB_DIR_RST)) u_dira (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_we    (i_wr & sel_dira),
        .i_wdata (i_wdata),
        .o_q     (dira_q)
    );
    // R17: port b direction clears at reset
    gpab_regs #(.W(8), .HAS_RST(1'b1), .RST_VAL(GPAB_DIR_RST)) u_dirb (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_we    (i_wr & sel_dirb),
        .i_wdata (i_wdata),
        .o_q     (dirb_q)
    );
    // led enables, cleared at reset
    gpab_regs #(.W(8), .HAS_RST(1'b1), .RST_VAL(GPAB_LED_RST)) u_port_a_led_drive_enable (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_we    (i_wr & sel_port_a_led_drive_enable),
        .i_wdata (i_wdata),
        .o_q     (port_a_led_drive_enable_q)
    );

    // R1: one-hot analog pick, none when channel is above port a
    wire       ach_ok   = (i_analog_channel_select < GPAB_ACH_PINS);
    wire [7:0] an_sel   = ach_ok ? (8'h01 << i_analog_channel_select[2:0]) : 8'h00;

    // R13: iic on pins 0,1  R14: serial on pins 2,3
    // R15: first timer on 4,5  R16: second timer on 6,7
    wire [7:0] pb_alt_en = {
        (i_t2c1_edge_level_select != GPAB_ELS_GPIO),
        (i_t2c0_edge_level_select != GPAB_ELS_GPIO),
        (i_t1c1_edge_level_select != GPAB_ELS_GPIO),
        (i_t1c0_edge_level_select != GPAB_ELS_GPIO),
        i_serial_block_enable,
        i_serial_block_enable,
        i_iic_block_enable,
        i_iic_block_enable
    };
    // receive pin is input-only while serial owns it
    wire [7:0] pb_alt_out = {i_timer_out, 1'b1, i_serial_txd, i_iic_scl_out, i_iic_sda_out};
    wire [7:0] pb_alt_oe  = {i_timer_oe, 1'b0, 1'b1, i_iic_scl_oe, i_iic_sda_oe};

    // per-pin muxes; a generate keeps the eight copies in one place
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_pin
            // R2: R3: R21: analog pick overrides direction on port a
            gpab_pin #(.OPEN_DRAIN(1'b0)) u_pa (
                .i_dir     (dira_q[g]),
                .i_latch   (pta_q[g]),
                .i_pin     (i_pa_pin[g]),
                .i_alt_en  (an_sel[g]),
                .i_alt_out (1'b0),
                .i_alt_oe  (1'b0),
                .o_out     (pa_out_d[g]),
                .o_oe      (pa_oe_d[g]),
                .o_rd      (pa_rd[g])
            );
            // R11: R18: R21: open-drain on low four port b pins
            gpab_pin #(.OPEN_DRAIN(GPAB_OD_MASK[g])) u_pb (
                .i_dir     (dirb_q[g]),
                .i_latch   (ptb_q[g]),
                .i_pin     (i_pb_pin[g]),
                .i_alt_en  (pb_alt_en[g]),
                .i_alt_out (pb_alt_out[g]),
                .i_alt_oe  (pb_alt_oe[g]),
                .o_out     (pb_out_d[g]),
                .o_oe      (pb_oe_d[g]),
                .o_rd      (pb_rd[g])
            );
        end
    endgenerate

    // R9: R10: high current only on driven, non-analog pins
    wire [7:0] led_d = port_a_led_drive_enable_q & dira_q & ~an_sel;

    // R6: R8: R19: read mux, latch or pin per direction
    wire [7:0] rd_mux = sel_pta  ? pa_rd  :
                        sel_ptb  ? pb_rd  :
                        sel_dira ? dira_q :
                        sel_dirb ? dirb_q :
                        sel_port_a_led_drive_enable ? port_a_led_drive_enable_q : GPAB_UNMAP_RD;

    // read data stands only in the cycle after the strobe
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= i_rd ? rd_mux : 8'h00;
        end
    end

    // registered pad drive; one cycle behind the registers
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            pa_out_q <= 8'h00;
            pa_oe_q  <= 8'h00;
            pa_led_q <= 8'h00;
            pa_an_q  <= 8'h00;
            pb_out_q <= 8'h00;
            pb_oe_q  <= 8'h00;
            pb_lvl_q <= 8'h00;
        end else begin
            pa_out_q <= pa_out_d;
            pa_oe_q  <= pa_oe_d;
            pa_led_q <= led_d;
            pa_an_q  <= an_sel;
            pb_out_q <= pb_out_d;
            pb_oe_q  <= pb_oe_d;
            pb_lvl_q <= i_pb_pin;
        end
    end

    assign o_rdata     = rdata_q;
    assign o_pa_out    = pa_out_q;
    assign o_pa_oe     = pa_oe_q;
    assign o_pa_led_hi = pa_led_q;
    assign o_pa_analog = pa_an_q;
    assign o_pb_out    = pb_out_q;
    assign o_pb_oe     = pb_oe_q;
    assign o_pb_level  = pb_lvl_q;

    // checks
    a_dira_reset: assert property (@(posedge i_clk) // R4
        !i_rst_n |=> (dira_q == 8'h00)) else $error("port a direction not cleared");
    a_dirb_reset: assert property (@(posedge i_clk) // R17
        !i_rst_n |=> (dirb_q == 8'h00)) else $error("port b direction not cleared");
    a_pa_drive: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R3
        1'b1 |=> (o_pa_oe == $past(dira_q & ~an_sel))) else $error("port a enable wrong");
    a_pa_analog: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R1
        1'b1 |=> ((o_pa_oe & o_pa_analog) == 8'h00)) else $error("analog pin driven");
    a_pta_read: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R6
        (i_rd && sel_pta) |=> (o_rdata == $past((pta_q & dira_q) | (i_pa_pin & ~dira_q))))
        else $error("port a read wrong");
    a_ptb_read: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R19
        (i_rd && sel_ptb) |=> (o_rdata == $past((ptb_q & dirb_q) | (i_pb_pin & ~dirb_q))))
        else $error("port b read wrong");
    a_pta_write: assert property (@(posedge i_clk) // R7
        (i_wr && sel_pta) |=> (pta_q == $past(i_wdata))) else $error("latch not written");
    // only a reset entered mid-run; the latch is unknown until first written
    a_ptb_keep: assert property (@(posedge i_clk) // R12
        (!i_rst_n && $past(i_rst_n) && !i_wr) |=> (ptb_q == $past(ptb_q)))
        else $error("port b latch lost");
    a_led_gate: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R9
        1'b1 |=> ((o_pa_led_hi & ~$past(dira_q)) == 8'h00)) else $error("led on input pin");
    a_od_high: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R11
        1'b1 |=> ((o_pb_out & o_pb_oe & GPAB_OD_MASK) == 8'h00)) else $error("od pin driven high");
    a_iic_take: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R13
        (i_iic_block_enable && !i_iic_sda_oe) |=> !o_pb_oe[0]) else $error("iic not in charge");
    a_rx_input: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R14
        i_serial_block_enable |=> !o_pb_oe[3]) else $error("receive pin driven");

    c_pa_out_read: cover property (@(posedge i_clk) i_rd && sel_pta && dira_q != 8'h00);
    c_iic_on:      cover property (@(posedge i_clk) i_iic_block_enable ##1 !i_iic_block_enable);
    c_led_on:      cover property (@(posedge i_clk) o_pa_led_hi != 8'h00);
    c_timer_pin:   cover property (@(posedge i_clk) pb_alt_en[7:4] != 4'h0);
endmodule

// file: sim/gpab_board.sv
// board model on the pads: external drivers and pull-ups
// assumes pad drive/enable from the block, levels fed back as pad inputs
`timescale 1ns/1ps
module gpab_board (
    input  wire logic [7:0] i_pa_out,
    input  wire logic [7:0] i_pa_oe,
    input  wire logic [7:0] i_pb_out,
    input  wire logic [7:0] i_pb_oe,
    input  wire logic [7:0] i_ext_a,
    input  wire logic [7:0] i_ext_b,
    output logic      [7:0] o_pa_pin,
    output logic      [7:0] o_pb_pin
);
    // port a: board drives only where the block floats
    assign o_pa_pin = (i_pa_oe & i_pa_out) | (~i_pa_oe & i_ext_a);
    // pull-ups on pb3..0
    // released open-drain lines rise, so a stuck oe shows as a low level
    assign o_pb_pin = (i_pb_oe & i_pb_out) | (~i_pb_oe & (i_ext_b | 8'h0f));
endmodule

// file: sim/tb_gpio_ports_a_b_with_led_drive.sv
// self-checking bench for the two-port gpio block
// assumes gpab_board closes the pad loop; inputs change on rising edges, except ext_a and ext_b, which change on falling edges
`timescale 1ns/1ps
module tb_gpio_ports_a_b_with_led_drive
    import gpab_pkg::*;
;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic [7:0] ext_a = 8'h00;
    logic [7:0] ext_b = 8'h00;
    logic [4:0] ach = 5'h1f;
    logic       iic_en = 1'b0;
    logic       sda_o = 1'b0;
    logic       sda_oe = 1'b0;
    logic       scl_o = 1'b0;
    logic       scl_oe = 1'b0;
    logic       sci_en = 1'b0;
    logic       txd = 1'b1;
    logic [1:0] els [4] = '{2'h0, 2'h0, 2'h0, 2'h0};
    logic [3:0] tout = 4'h0;
    logic [3:0] toe = 4'h0;
    wire  [7:0] rdata, pa_out, pa_oe, led, ana, pb_out, pb_oe, pb_lvl, pa_pin, pb_pin;
    int         num_errors = 0;
    int         num_checks = 0;
    int         cyc = 0;

    gpab_top uut (.i_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_pa_pin(pa_pin), .o_pa_out(pa_out),
        .o_pa_oe(pa_oe), .o_pa_led_hi(led), .o_pa_analog(ana), .i_pb_pin(pb_pin),
        .o_pb_out(pb_out), .o_pb_oe(pb_oe), .i_analog_channel_select(ach),
        .i_iic_block_enable(iic_en), .i_iic_sda_out(sda_o), .i_iic_sda_oe(sda_oe),
        .i_iic_scl_out(scl_o), .i_iic_scl_oe(scl_oe), .i_serial_block_enable(sci_en),
        .i_serial_txd(txd), .i_t1c0_edge_level_select(els[0]),
        .i_t1c1_edge_level_select(els[1]), .i_t2c0_edge_level_select(els[2]),
        .i_t2c1_edge_level_select(els[3]), .i_timer_out(tout), .i_timer_oe(toe),
        .o_pb_level(pb_lvl));
    gpab_board board (.i_pa_out(pa_out), .i_pa_oe(pa_oe), .i_pb_out(pb_out),
        .i_pb_oe(pb_oe), .i_ext_a(ext_a), .i_ext_b(ext_b), .o_pa_pin(pa_pin),
        .o_pb_pin(pb_pin));

    // 200 MHz clock
    initial begin
        forever #2.5 clk = ~clk;
    end
    // hang guard, far above the run length
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            summarize();
        end
    end

    task automatic summarize;
        if (num_errors == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one-cycle write strobe; a gap cycle keeps strobe edges apart
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
    // pads follow one edge after a register, levels one edge later
    task automatic settle;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic do_reset;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
    endtask

    task automatic t_reset_vals;
        logic [7:0] d;
        rd_reg(GPAB_OFF_DIRA, d);
        chk(d, GPAB_DIR_RST);
        rd_reg(GPAB_OFF_DIRB, d);
        chk(d, GPAB_DIR_RST);
        rd_reg(GPAB_OFF_PORT_A_LED_DRIVE_ENABLE, d);
        chk(d, GPAB_LED_RST);
        rd_reg(4'h9, d);
        chk(d, GPAB_UNMAP_RD);
        chk(pa_oe | pb_oe, 8'h00);
    endtask
    task automatic t_porta;
        logic [7:0] d;
        ext_a <= 8'h3c;
        wr_reg(GPAB_OFF_PTA, 8'ha5);
        wr_reg(GPAB_OFF_DIRA, 8'h0f);
        settle();
        chk(pa_oe, 8'h0f);
        chk(pa_out & 8'h0f, 8'h05);
        rd_reg(GPAB_OFF_PTA, d);
        chk(d, 8'h35);
        wr_reg(GPAB_OFF_PTA, 8'hff);
        rd_reg(GPAB_OFF_PTA, d);
        chk(d, 8'h3f);
        wr_reg(GPAB_OFF_DIRA, 8'hff);
        settle();
        rd_reg(GPAB_OFF_PTA, d);
        chk(d, 8'hff);
        wr_reg(GPAB_OFF_DIRA, 8'h0f);
    endtask
    task automatic t_led;
        wr_reg(GPAB_OFF_PORT_A_LED_DRIVE_ENABLE, 8'hf0);
        settle();
        chk(led, 8'h00);
        wr_reg(GPAB_OFF_PORT_A_LED_DRIVE_ENABLE, 8'hff);
        settle();
        chk(led, 8'h0f);
        @(posedge clk);
        ach <= 5'h02;
        settle();
        chk(ana, 8'h04);
        chk(pa_oe, 8'h0b);
        chk(led, 8'h0b);
        @(posedge clk);
        ach <= 5'h08;
        settle();
        chk(ana, 8'h00);
        chk(pa_oe, 8'h0f);
    endtask
    task automatic t_portb;
        logic [7:0] d;
        ext_b <= 8'h30;
        wr_reg(GPAB_OFF_PTB, 8'hca);
        wr_reg(GPAB_OFF_DIRB, 8'h0f);
        settle();
        chk(pb_out & GPAB_OD_MASK, 8'h00);
        chk(pb_lvl, 8'h3a);
        chk(pb_oe & 8'hf0, 8'h00);
        rd_reg(GPAB_OFF_PTB, d);
        chk(d, 8'h3a);
        wr_reg(GPAB_OFF_DIRB, 8'hff);
        settle();
        chk(pb_out & 8'hf0, 8'hc0);
        chk(pb_oe & 8'hf0, 8'hf0);
    endtask
    task automatic t_alt;
        @(posedge clk);
        iic_en <= 1'b1;
        scl_oe <= 1'b1;
        sci_en <= 1'b1;
        els <= '{2'h1, 2'h2, 2'h3, 2'h1};
        tout <= 4'h5;
        toe <= 4'hf;
        settle();
        chk(pb_lvl, 8'h5d);
        chk(pb_oe & 8'h08, 8'h00);
        @(posedge clk);
        toe <= 4'h0;
        txd <= 1'b0;
        settle();
        chk(pb_lvl, 8'h39);
        @(posedge clk);
        iic_en <= 1'b0;
        sci_en <= 1'b0;
        els <= '{GPAB_ELS_GPIO, GPAB_ELS_GPIO, GPAB_ELS_GPIO, GPAB_ELS_GPIO};
        settle();
        chk(pb_lvl, 8'hca);
    endtask
    task automatic t_keep_latch;
        logic [7:0] d;
        wr_reg(GPAB_OFF_PTA, 8'h5a);
        wr_reg(GPAB_OFF_PTB, 8'hc3);
        do_reset();
        rd_reg(GPAB_OFF_DIRA, d);
        chk(d, 8'h00);
        wr_reg(GPAB_OFF_DIRA, 8'hff);
        wr_reg(GPAB_OFF_DIRB, 8'hff);
        rd_reg(GPAB_OFF_PTA, d);
        chk(d, 8'h5a);
        rd_reg(GPAB_OFF_PTB, d);
        chk(d, 8'hc3);
    endtask

    // main sequence
    initial begin
        do_reset();
        t_reset_vals();
        t_porta();
        t_led();
        t_portb();
        t_alt();
        t_keep_latch();
        summarize();
    end
endmodule
